//--- inc/gpio_defs.svh
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

// =====================================================================
// register indices (byte address = index * 4)
`define BANK_A_IDX       14'h0000
`define BANK_B_IDX       14'h0008
`define BANK_C_IDX       14'h0010
`define CHG_STATUS_IDX   14'h0018
`define CHG_FLAG_IDX     14'h0019
`define RISE_EN_IDX      14'h1f53

// =====================================================================
// widths and masks
`define BANK_A_W         6
`define BANK_B_W         4
`define BANK_C_W         8
`define BANK_C_SMALL_MSK 8'h3f
`define BANK_C_LARGE_MSK 8'hff
`define FLAG_BIT         0

// =====================================================================
// reset values
`define DIR_RST          8'hff
`define CTRL_RST         8'h00
`define RISE_EN_RST      8'h00

`endif

//--- inc/gpio_pkg.sv
package gpio_pkg;

    // =================================================================
    // per-bank register slot, low three bits of the register index
    typedef enum logic [2:0] {
        SEL_PIN_LEVEL   = 3'h0,
        SEL_OUTPUT_HOLD = 3'h1,
        SEL_DIRECTION   = 3'h2,
        SEL_ANALOG      = 3'h3,
        SEL_PULLUP      = 3'h4,
        SEL_THRESHOLD   = 3'h5,
        SEL_SLEW        = 3'h6,
        SEL_OPEN_DRAIN  = 3'h7
    } bank_reg_t;

    typedef logic [13:0] reg_idx_t;

endpackage

//--- logic/gpio_bank.sv
`timescale 1ns/1ps
`include "gpio_defs.svh"

module gpio_bank
    import gpio_pkg::*;
#(
    parameter int         W    = `BANK_A_W,
    parameter logic [W-1:0] IMPL = '1
) (
    input  wire logic         clk,        // system clock
    input  wire logic         rst_n,      // async reset, active low
    input  wire logic         wr_en,      // register write strobe
    input  gpio_pkg::bank_reg_t sel,      // register slot
    input  wire logic [W-1:0] wdata,      // write data
    input  wire logic [W-1:0] pad_in,     // raw pin levels
    input  wire logic [W-1:0] periph_en,  // peripheral owns the pin
    input  wire logic [W-1:0] periph_out, // peripheral drive value
    output logic      [W-1:0] pad_out,    // pin output value
    output logic      [W-1:0] pad_oe,     // pin output enable
    output logic      [W-1:0] pull_en,    // weak pull-up enables
    output logic      [W-1:0] thresh,     // input threshold select
    output logic      [W-1:0] slew,       // slew limit enables
    output logic      [W-1:0] din,        // digital pin levels
    output logic      [W-1:0] rdata       // selected register value
);

    logic [W-1:0] hold_ff, dir_ff, ana_ff, wpu_ff, thr_ff, slew_ff, od_ff;
    logic [W-1:0] sync1_ff, sync2_ff, din_ff, out_ff, oe_ff;
    logic [W-1:0] drive, nxt_out, nxt_oe, wmask;

    // =================================================================
    // writes: pin level and output hold both land in the latch
    function automatic logic [W-1:0] merge(input logic [W-1:0] old);
        return (wdata & IMPL) | (old & ~IMPL);
    endfunction

    wire wr_hold = wr_en && (sel == SEL_PIN_LEVEL || sel == SEL_OUTPUT_HOLD); // [RULE_04]
    assign wmask = IMPL;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_ff <= W'(`CTRL_RST);
            dir_ff  <= W'(`DIR_RST);
            ana_ff  <= W'(`CTRL_RST);
            wpu_ff  <= W'(`CTRL_RST);
            thr_ff  <= W'(`CTRL_RST);
            slew_ff <= W'(`CTRL_RST);
            od_ff   <= W'(`CTRL_RST);
        end else begin
            if (wr_hold) hold_ff <= merge(hold_ff);                      // [RULE_04]
            if (wr_en && sel == SEL_DIRECTION)  dir_ff  <= merge(dir_ff);  // [RULE_02]
            if (wr_en && sel == SEL_ANALOG)     ana_ff  <= merge(ana_ff);
            if (wr_en && sel == SEL_PULLUP)     wpu_ff  <= merge(wpu_ff);
            if (wr_en && sel == SEL_THRESHOLD)  thr_ff  <= merge(thr_ff);
            if (wr_en && sel == SEL_SLEW)       slew_ff <= merge(slew_ff);
            if (wr_en && sel == SEL_OPEN_DRAIN) od_ff   <= merge(od_ff);
        end
    end

    // =================================================================
    // pin input: two flops, then the analog select blanks the buffer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            din_ff   <= '0;
        end else begin
            sync1_ff <= pad_in;
            sync2_ff <= sync1_ff;
            din_ff   <= sync2_ff & ~ana_ff & wmask;             // [RULE_06]
        end
    end

    // =================================================================
    // pin drive; open drain only ever pulls low
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            assign drive[i]   = periph_en[i] ? periph_out[i] : hold_ff[i]; // [RULE_03]
            assign nxt_out[i] = od_ff[i] ? 1'b0 : drive[i];
            assign nxt_oe[i]  = !dir_ff[i] && (!od_ff[i] || !drive[i]);    // [RULE_13]
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= '0;
            oe_ff  <= '0;
        end else begin
            out_ff <= nxt_out;
            oe_ff  <= nxt_oe;
        end
    end

    assign pad_out = out_ff;
    assign pad_oe  = oe_ff;
    assign pull_en = wpu_ff;
    assign thresh  = thr_ff;
    assign slew    = slew_ff;
    assign din     = din_ff;

    // level slot shows the pins, hold slot shows the latch
    assign rdata = IMPL & ((sel == SEL_PIN_LEVEL)   ? din_ff  :     // [RULE_05]
                           (sel == SEL_OUTPUT_HOLD) ? hold_ff :
                           (sel == SEL_DIRECTION)   ? dir_ff  :
                           (sel == SEL_ANALOG)      ? ana_ff  :
                           (sel == SEL_PULLUP)      ? wpu_ff  :
                           (sel == SEL_THRESHOLD)   ? thr_ff  :
                           (sel == SEL_SLEW)        ? slew_ff : od_ff);

    // =================================================================
    latch_write_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
        wr_hold |=> hold_ff == (($past(wdata) & IMPL) | ($past(hold_ff) & ~IMPL)))
        else $error("level or hold write did not update the latch");

    periph_drive_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
        (periph_en[0] && !od_ff[0]) |=> pad_out[0] == $past(periph_out[0]))
        else $error("latch drove a pin owned by a peripheral");

    dir_input_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_13]
        dir_ff[0] |=> !pad_oe[0])
        else $error("input pin is being driven");

    analog_blank_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
        ana_ff[0] |=> !din[0])
        else $error("digital input followed an analog pin");

endmodule

//--- logic/gpio_port_top.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "gpio_defs.svh"

// Contract
// RULE_01 - the block has bidirectional bank A of 6 pins, bank B of 4 pins only on the large variant, and bank C of 6 or 8 pins.
// RULE_02 - each bank has pin level, output hold, direction, analog, pull-up, threshold, slew and open-drain controls.
// RULE_03 - a pin owned by a peripheral is not driven from the output latch but still reads its level.
// RULE_04 - writing the pin level register or the output hold register both update the output latch.
// RULE_05 - the output hold register reads the latch while the pin level register reads the pins.
// RULE_06 - an analog select bit disables the digital input of its pin.
// RULE_07 - software should do read-modify-write of outputs through the output hold register.
// RULE_08 - with its rise enable set, a rising edge on a bank C pin sets its status bit and the change flag.
// RULE_09 - with its rise enable clear, a bank C pin detects no edge.
// RULE_10 - the bank C rise enable register has eight read/write bits that reset to zero.
// RULE_11 - rise enable bits 6 and 7 exist only on the large variant.
// RULE_12 - a rising edge is found by comparing the synchronised sample with the previous one on the system clock.
// RULE_13 - direction 1 makes the pin an input with the driver off, direction 0 drives the latch.

module gpio_port_top #(
    parameter bit LARGE_PKG = 1'b1
) (
    input  wire logic                 pclk,          // system clock, 25 MHz
    input  wire logic                 presetn,       // async reset, active low
    input  wire logic                 psel,          // apb select
    input  wire logic                 penable,       // apb enable
    input  wire logic                 pwrite,        // apb direction
    input  wire logic [15:0]          paddr,         // apb byte address
    input  wire logic [31:0]          pwdata,        // apb write data
    output logic      [31:0]          prdata,        // apb read data
    output logic                      pready,        // apb ready
    output logic                      pslverr,       // apb error
    input  wire logic [`BANK_A_W-1:0] a_in,          // bank A pin levels
    input  wire logic [`BANK_A_W-1:0] a_periph_en,   // bank A peripheral owns pin
    input  wire logic [`BANK_A_W-1:0] a_periph_out,  // bank A peripheral value
    output logic      [`BANK_A_W-1:0] a_out,         // bank A drive value
    output logic      [`BANK_A_W-1:0] a_oe,          // bank A drive enable
    output logic      [`BANK_A_W-1:0] a_pullup,      // bank A pull-ups
    output logic      [`BANK_A_W-1:0] a_thresh,      // bank A threshold select
    output logic      [`BANK_A_W-1:0] a_slew,        // bank A slew limit
    input  wire logic [`BANK_B_W-1:0] b_in,          // bank B pin levels
    input  wire logic [`BANK_B_W-1:0] b_periph_en,   // bank B peripheral owns pin
    input  wire logic [`BANK_B_W-1:0] b_periph_out,  // bank B peripheral value
    output logic      [`BANK_B_W-1:0] b_out,         // bank B drive value
    output logic      [`BANK_B_W-1:0] b_oe,          // bank B drive enable
    output logic      [`BANK_B_W-1:0] b_pullup,      // bank B pull-ups
    output logic      [`BANK_B_W-1:0] b_thresh,      // bank B threshold select
    output logic      [`BANK_B_W-1:0] b_slew,        // bank B slew limit
    input  wire logic [`BANK_C_W-1:0] c_in,          // bank C pin levels
    input  wire logic [`BANK_C_W-1:0] c_periph_en,   // bank C peripheral owns pin
    input  wire logic [`BANK_C_W-1:0] c_periph_out,  // bank C peripheral value
    output logic      [`BANK_C_W-1:0] c_out,         // bank C drive value
    output logic      [`BANK_C_W-1:0] c_oe,          // bank C drive enable
    output logic      [`BANK_C_W-1:0] c_pullup,      // bank C pull-ups
    output logic      [`BANK_C_W-1:0] c_thresh,      // bank C threshold select
    output logic      [`BANK_C_W-1:0] c_slew,        // bank C slew limit
    output logic                      change_flag    // rise change flag, sticky
);
    import gpio_pkg::*;

    // =================================================================
    // variant shaping
    localparam logic [`BANK_C_W-1:0] C_IMPL =
        LARGE_PKG ? `BANK_C_LARGE_MSK : `BANK_C_SMALL_MSK;          // [RULE_01] [RULE_11]

    // =================================================================
    // address decode
    function automatic logic bank_hit(input reg_idx_t idx, input reg_idx_t base);
        return idx[13:3] == base[13:3];
    endfunction

    reg_idx_t   idx;
    bank_reg_t  slot;
    logic       hit_a, hit_b, hit_c, hit_stat, hit_flag, hit_en, mapped;
    logic       setup, access_done, wr_go;

    assign idx      = paddr[15:2];
    assign slot     = bank_reg_t'(idx[2:0]);
    assign hit_a    = bank_hit(idx, `BANK_A_IDX);
    assign hit_b    = bank_hit(idx, `BANK_B_IDX) && LARGE_PKG;      // [RULE_01]
    assign hit_c    = bank_hit(idx, `BANK_C_IDX);
    assign hit_stat = idx == `CHG_STATUS_IDX;
    assign hit_flag = idx == `CHG_FLAG_IDX;
    assign hit_en   = idx == `RISE_EN_IDX;
    assign mapped   = hit_a || hit_b || hit_c || hit_stat || hit_flag || hit_en;

    // one wait-free answer: ready rises in the first access cycle
    logic        pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;

    assign setup       = psel && !penable;
    assign access_done = psel && penable && pready_ff;
    assign wr_go       = access_done && pwrite && mapped;

    // =================================================================
    // the three banks
    logic [`BANK_A_W-1:0] a_din, a_rdata;
    logic [`BANK_B_W-1:0] b_din, b_rdata;
    logic [`BANK_C_W-1:0] c_din, c_rdata;

    gpio_bank #(.W(`BANK_A_W), .IMPL('1)) bank_a (                  // [RULE_01] [RULE_02]
        .clk        (pclk),
        .rst_n      (presetn),
        .wr_en      (wr_go && hit_a),
        .sel        (slot),
        .wdata      (pwdata[`BANK_A_W-1:0]),
        .pad_in     (a_in),
        .periph_en  (a_periph_en),
        .periph_out (a_periph_out),
        .pad_out    (a_out),
        .pad_oe     (a_oe),
        .pull_en    (a_pullup),
        .thresh     (a_thresh),
        .slew       (a_slew),
        .din        (a_din),
        .rdata      (a_rdata)
    );

    // on the small variant bank B exists but is never addressable
    gpio_bank #(.W(`BANK_B_W), .IMPL('1)) bank_b (                  // [RULE_01] [RULE_02]
        .clk        (pclk),
        .rst_n      (presetn),
        .wr_en      (wr_go && hit_b),
        .sel        (slot),
        .wdata      (pwdata[`BANK_B_W-1:0]),
        .pad_in     (b_in),
        .periph_en  (b_periph_en & {`BANK_B_W{LARGE_PKG}}),
        .periph_out (b_periph_out),
        .pad_out    (b_out),
        .pad_oe     (b_oe),
        .pull_en    (b_pullup),
        .thresh     (b_thresh),
        .slew       (b_slew),
        .din        (b_din),
        .rdata      (b_rdata)
    );

    gpio_bank #(.W(`BANK_C_W), .IMPL(C_IMPL)) bank_c (              // [RULE_01] [RULE_02]
        .clk        (pclk),
        .rst_n      (presetn),
        .wr_en      (wr_go && hit_c),
        .sel        (slot),
        .wdata      (pwdata[`BANK_C_W-1:0]),
        .pad_in     (c_in),
        .periph_en  (c_periph_en & C_IMPL),
        .periph_out (c_periph_out),
        .pad_out    (c_out),
        .pad_oe     (c_oe),
        .pull_en    (c_pullup),
        .thresh     (c_thresh),
        .slew       (c_slew),
        .din        (c_din),
        .rdata      (c_rdata)
    );

    // =================================================================
    // bank C rise detection
    logic [`BANK_C_W-1:0] rise_en_ff, status_ff, rise, stat_clr;
    logic [`BANK_C_W-1:0] nxt_rise_en, nxt_status;
    logic                 flag_ff, flag_clr, nxt_flag;

    rise_detect #(.W(`BANK_C_W)) c_edges (
        .clk    (pclk),
        .rst_n  (presetn),
        .din    (c_din),
        .enable (rise_en_ff),
        .rise   (rise)
    );

    assign nxt_rise_en = (wr_go && hit_en) ? (pwdata[`BANK_C_W-1:0] & C_IMPL)
                                           : rise_en_ff;          // [RULE_10] [RULE_11]
    // write one to clear; an edge in the same cycle wins over the clear
    assign stat_clr    = (wr_go && hit_stat) ? pwdata[`BANK_C_W-1:0] : '0;
    assign flag_clr    = wr_go && hit_flag && pwdata[`FLAG_BIT];
    assign nxt_status  = (status_ff & ~stat_clr) | rise;            // [RULE_08]
    assign nxt_flag    = (flag_ff && !flag_clr) || (|rise);        // [RULE_08]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_en_ff <= `RISE_EN_RST;                               // [RULE_10]
            status_ff  <= `CTRL_RST;
            flag_ff    <= 1'b0;
        end else begin
            rise_en_ff <= nxt_rise_en;
            status_ff  <= nxt_status;
            flag_ff    <= nxt_flag;
        end
    end

    assign change_flag = flag_ff;

    // =================================================================
    // apb answer, sampled in the setup cycle
    logic [31:0] rd_word;

    assign rd_word = hit_a    ? 32'(a_rdata)          :             // [RULE_05]
                     hit_b    ? 32'(b_rdata)          :
                     hit_c    ? 32'(c_rdata)          :
                     hit_stat ? 32'(status_ff)        :
                     hit_flag ? 32'(flag_ff)          :
                     hit_en   ? 32'(rise_en_ff)       : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !mapped;
            prdata_ff  <= (setup && !pwrite) ? rd_word : prdata_ff;
        end
    end

    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata  = prdata_ff;

    // =================================================================
    // checks
    level_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
        (setup && !pwrite && hit_a && slot == SEL_PIN_LEVEL)
            |=> prdata[`BANK_A_W-1:0] == $past(a_din))
        else $error("pin level read did not return pin state");

    rise_sets_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08]
        rise[0] |=> status_ff[0] && change_flag)
        else $error("enabled rise did not set status and flag");

    no_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
        (!rise_en_ff[0] && !status_ff[0]) |=> !status_ff[0])
        else $error("status set on a disabled pin");

    enable_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
        (wr_go && hit_en) |=> rise_en_ff == ($past(pwdata[`BANK_C_W-1:0]) & C_IMPL))
        else $error("rise enable write lost");

    upper_enable_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
        !LARGE_PKG |-> rise_en_ff[7:6] == 2'b00)
        else $error("unimplemented enable bits set");

    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("ready not a single access cycle");

    set_wins_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08]
        (rise[1] && stat_clr[1]) |=> status_ff[1])
        else $error("clear beat a simultaneous rise");

    cov_read_c: cover property (@(posedge pclk) access_done && !pwrite && hit_c);
    cov_rise_c: cover property (@(posedge pclk) rise != '0 ##1 change_flag);
    cov_unmap_c: cover property (@(posedge pclk) access_done && pslverr);
    cov_flag_clr_c: cover property (@(posedge pclk) change_flag ##1 flag_clr ##1 !change_flag);

endmodule

//--- logic/rise_detect.sv
`timescale 1ns/1ps
`include "gpio_defs.svh"

module rise_detect #(
    parameter int W = `BANK_C_W
) (
    input  wire logic         clk,      // system clock
    input  wire logic         rst_n,    // async reset, active low
    input  wire logic [W-1:0] din,      // synchronised pin levels
    input  wire logic [W-1:0] enable,   // per-pin rise enables
    output logic      [W-1:0] rise      // rising edge seen this cycle
);

    logic [W-1:0] prev_ff;

    // =================================================================
    // compare with the previous sample; a disabled pin never reports
    assign rise = din & ~prev_ff & enable;                  // [RULE_12] [RULE_09]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= din;
        end
    end

    // =================================================================
    rise_timing_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
        (din[0] && !$past(din[0]) && enable[0]) |-> rise[0])
        else $error("enabled rising edge not reported in its cycle");

endmodule

//--- tb/gpio_port_with_edge_detect_bench.sv
`timescale 1ns/1ps
`include "gpio_defs.svh"

module gpio_port_with_edge_detect_bench;
    import gpio_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, change_flag, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  a_in, a_periph_en, a_periph_out, a_out, a_oe, a_pullup, a_thresh, a_slew;
    logic [5:0]  a_xd, a_xv;
    logic [3:0]  b_in, b_periph_en, b_periph_out, b_out, b_oe, b_pullup, b_thresh, b_slew;
    logic [7:0]  c_in, c_periph_en, c_periph_out, c_out, c_oe, c_pullup, c_thresh, c_slew;
    logic [7:0]  c_xv;
    int          mismatches, checks_done;

    gpio_port_top gpio_port_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .a_in, .a_periph_en, .a_periph_out, .a_out,
        .a_oe, .a_pullup, .a_thresh, .a_slew, .b_in, .b_periph_en, .b_periph_out, .b_out,
        .b_oe, .b_pullup, .b_thresh, .b_slew, .c_in, .c_periph_en, .c_periph_out, .c_out,
        .c_oe, .c_pullup, .c_thresh, .c_slew, .change_flag);
    pin_model #(.W(6)) a_pins (.clk(pclk), .out(a_out), .oe(a_oe), .pull_en(a_pullup),
        .ext_drv(a_xd), .ext_val(a_xv), .level(a_in));
    pin_model #(.W(4)) b_pins (.clk(pclk), .out(b_out), .oe(b_oe), .pull_en(b_pullup),
        .ext_drv(a_xd[3:0]), .ext_val(a_xv[3:0]), .level(b_in));
    pin_model #(.W(8)) c_pins (.clk(pclk), .out(c_out), .oe(c_oe), .pull_en(c_pullup),
        .ext_drv(~c_oe), .ext_val(c_xv), .level(c_in));

    // =================================================================
    // bus tasks and checks
    task automatic complete_run();
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input reg_idx_t idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        if (n == 16) begin
            mismatches++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input reg_idx_t idx, input logic [31:0] exp, input string nm);
        apb(1'b0, idx, 32'h0000_0000);
        chk(nm, exp, rd);
    endtask

    function automatic reg_idx_t ax(input bank_reg_t s);
        return `BANK_A_IDX + reg_idx_t'(s);
    endfunction

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // =================================================================
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {a_periph_en, a_periph_out, b_periph_en, b_periph_out, a_xd, a_xv} = '0;
        {c_periph_en, c_periph_out, c_xv, mismatches, checks_done} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`RISE_EN_IDX, 32'h0000_0000, "rise_en_rst");
        rchk(ax(SEL_DIRECTION), 32'h0000_003f, "a_dir_rst");
        chk("a_oe_rst", 32'h0000_0000, {26'h0, a_oe});
        apb(1'b1, ax(SEL_DIRECTION), 32'h0000_0000);
        apb(1'b1, ax(SEL_PIN_LEVEL), 32'h0000_0015);
        rchk(ax(SEL_OUTPUT_HOLD), 32'h0000_0015, "a_hold");
        rchk(ax(SEL_PIN_LEVEL), 32'h0000_0015, "a_pins_driven");
        chk("a_out", 32'h0000_0015, {26'h0, a_out});
        chk("a_oe", 32'h0000_003f, {26'h0, a_oe});
        apb(1'b0, ax(SEL_OUTPUT_HOLD), 32'h0000_0000);
        apb(1'b1, ax(SEL_OUTPUT_HOLD), rd | 32'h0000_0002);
        // latch and pin views must part once the board drives the pins
        a_xd <= 6'h3f;
        a_xv <= 6'h0c;
        apb(1'b1, ax(SEL_DIRECTION), 32'h0000_003f);
        repeat (4) @(posedge pclk);
        rchk(ax(SEL_PIN_LEVEL), 32'h0000_000c, "a_pins_in");
        rchk(ax(SEL_OUTPUT_HOLD), 32'h0000_0017, "a_hold_kept");
        a_xd <= 6'h00;
        a_periph_en <= 6'h01;
        apb(1'b1, ax(SEL_DIRECTION), 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk("a_out_periph", 32'h0000_0016, {26'h0, a_out});
        repeat (4) @(posedge pclk);
        rchk(ax(SEL_PIN_LEVEL), 32'h0000_0016, "a_pins_periph");
        a_periph_en <= 6'h00;
        apb(1'b1, ax(SEL_ANALOG), 32'h0000_0001);
        repeat (4) @(posedge pclk);
        rchk(ax(SEL_PIN_LEVEL), 32'h0000_0016, "a_analog");
        apb(1'b1, ax(SEL_OPEN_DRAIN), 32'h0000_003f);
        repeat (2) @(posedge pclk);
        chk("a_od", 32'h0000_0a00, {20'h0, a_oe, a_out});
        for (int s = 4; s < 7; s++) begin
            apb(1'b1, `BANK_C_IDX + reg_idx_t'(s), 32'h0000_005a);
        end
        @(posedge pclk);
        chk("c_ctrl", 32'h005a_5a5a, {8'h0, c_pullup, c_thresh, c_slew});
        apb(1'b1, `BANK_B_IDX + 14'h0001, 32'h0000_000f);
        rchk(`BANK_B_IDX + 14'h0001, 32'h0000_000f, "b_hold");
        chk("b_drive", 32'h0000_000f, {24'h0, b_oe, b_out});
        apb(1'b1, `RISE_EN_IDX, 32'h0000_0005);
        rchk(`RISE_EN_IDX, 32'h0000_0005, "rise_en");
        c_xv <= 8'h0f;
        repeat (6) @(posedge pclk);
        rchk(`CHG_STATUS_IDX, 32'h0000_0005, "status");
        chk("flag", 32'h0000_0001, {31'h0, change_flag});
        apb(1'b1, `CHG_STATUS_IDX, 32'h0000_00ff);
        apb(1'b1, `CHG_FLAG_IDX, 32'h0000_0001);
        apb(1'b1, `RISE_EN_IDX, 32'h0000_00ff);
        rchk(`RISE_EN_IDX, 32'h0000_00ff, "rise_en_all");
        rchk(`CHG_STATUS_IDX, 32'h0000_0000, "status_clr");
        chk("flag_clr", 32'h0000_0000, {31'h0, change_flag});
        c_xv <= 8'hf0;
        repeat (6) @(posedge pclk);
        rchk(`CHG_STATUS_IDX, 32'h0000_00f0, "status_hi");
        apb(1'b0, 14'h001a, 32'h0000_0000);
        chk("unmapped_err", 32'h0000_0001, {31'h0, err});
        chk("unmapped_data", 32'h0000_0000, rd);
        complete_run();
    end
endmodule

//--- tb/pin_model.sv
`timescale 1ns/1ps

// =====================================================================
// board side of one bank: driven pins, board drivers, pull-ups
module pin_model #(
    parameter int W = 6
) (
    input  wire logic         clk,      // system clock
    input  wire logic [W-1:0] out,      // block drive value
    input  wire logic [W-1:0] oe,       // block drives the pin
    input  wire logic [W-1:0] pull_en,  // weak pull-up on
    input  wire logic [W-1:0] ext_drv,  // board drives the pin
    input  wire logic [W-1:0] ext_val,  // board drive value
    output logic      [W-1:0] level     // resolved pin level
);
    logic flip_ff;

    initial flip_ff = 1'b0;
    // a floating pin without pull-up wanders, so no stale level can pass
    always @(posedge clk) flip_ff <= ~flip_ff;
    assign level = (oe & out) | (~oe & ext_drv & ext_val)
                 | (~oe & ~ext_drv & (pull_en | {W{flip_ff}}));
endmodule
